//--- shared/fpt_map.vh
`ifndef FPT_MAP_VH
`define FPT_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FPT_CTRL_OFF 8'h00
`define FPT_POS_OFF 8'h04
`define FPT_TDLY_OFF 8'h08
`define FPT_TSLOT_OFF 8'h0c
`define FPT_STAT_OFF 8'h10
`define FPT_PCNT_OFF 8'h14
`define FPT_MCNT_OFF 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FPT_CTRL_POS_EN 0
`define FPT_CTRL_ARM 1
`define FPT_CTRL_SEQ_EN 2
`define FPT_POS_BIT_MSB 7
`define FPT_POS_SLOT_LSB 8
`define FPT_POS_SLOT_MSB 10
`define FPT_STAT_BIT_LSB 8
`define FPT_STAT_BIT_MSB 15
`define FPT_STAT_MEAS_LVL 16
`define FPT_STAT_BUSY 17
`define FPT_STAT_POS_REJ 18
`define FPT_STAT_POS_TRIG 19

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define FPT_CTRL_RST 3'h0
`define FPT_POS_RST 11'h000
`define FPT_TDLY_RST 16'h0000
`define FPT_TSLOT_RST 3'h0
`define FPT_MAX_BIT 8'h9c
`define FPT_LAST_BIT_LONG 8'h9c
`define FPT_LAST_BIT_SHORT 8'h9b

// ----------------------------------------
// Timing: one bit lasts FPT_BIT_NUM_NS / FPT_BIT_DEN ns
// ----------------------------------------
`define FPT_CLK_NS 50
`define FPT_BIT_NUM_NS 48000
`define FPT_BIT_DEN 13
`define FPT_BIT_STEP (`FPT_CLK_NS * `FPT_BIT_DEN)

`endif

//--- hw/fpt_frame_cnt.v
`timescale 1ns/100ps
`include "fpt_map.vh"

module fpt_frame_cnt (
  input wire pclk,
  input wire presetn,
  input wire bit_en,
  output reg [2:0] slot_r,
  output reg [7:0] bit_r
);

  // ----------------------------------------
  // Slot length
  // ----------------------------------------
  // Slots 0 and 4 carry 157 bits and the rest 156, so every fourth slot
  // start lands exactly on the nominal 156.25 bit grid.
  function [7:0] last_bit;
    input [2:0] slot;
    begin
      last_bit = (slot[1:0] == 2'b00) ? `FPT_LAST_BIT_LONG : `FPT_LAST_BIT_SHORT;
    end
  endfunction

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_r <= 3'h0;
      bit_r <= 8'h00;
    end else if (bit_en) begin
      if (bit_r == last_bit(slot_r)) begin
        bit_r <= 8'h00;
        slot_r <= slot_r + 3'h1;
      end else begin
        bit_r <= bit_r + 8'h01;
      end
    end
  end

endmodule

//--- hw/fpt_meas_dly.v
`timescale 1ns/100ps

module fpt_meas_dly #(
  parameter DW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire bit_en,
  input wire start,
  input wire arm,
  input wire [DW-1:0] delay,
  output reg trig_lvl_r,
  output reg busy_r,
  output reg go_r
);

  reg [DW-1:0] cnt_r;

  // ----------------------------------------
  // Delay and trigger transition
  // ----------------------------------------
  // A start that comes while a delay is still running is ignored, so a
  // long delay yields one measurement per delay window, not a backlog.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {DW{1'b0}};
      busy_r <= 1'b0;
      trig_lvl_r <= 1'b0;
      go_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      if (!arm) begin
        busy_r <= 1'b0;
      end else if (!busy_r) begin
        if (start) begin
          busy_r <= 1'b1;
          cnt_r <= delay;
        end
      end else if (bit_en) begin
        if (cnt_r == {DW{1'b0}}) begin
          busy_r <= 1'b0;
          go_r <= 1'b1;
          trig_lvl_r <= ~trig_lvl_r;
        end else begin
          cnt_r <= cnt_r - {{(DW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

//--- hw/fpt_top.v
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "fpt_map.vh"

module fpt_top #(
  parameter DLY_W = 16,
  parameter CNT_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg pos_trig,
  output wire meas_trig_out,
  output wire meas_busy,
  output reg burst_start
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function addr_known;
    input [7:0] a;
    begin
      case (a)
        `FPT_CTRL_OFF: addr_known = 1'b1;
        `FPT_POS_OFF: addr_known = 1'b1;
        `FPT_TDLY_OFF: addr_known = 1'b1;
        `FPT_TSLOT_OFF: addr_known = 1'b1;
        `FPT_STAT_OFF: addr_known = 1'b1;
        `FPT_PCNT_OFF: addr_known = 1'b1;
        `FPT_MCNT_OFF: addr_known = 1'b1;
        default: addr_known = 1'b0;
      endcase
    end
  endfunction

  // A position beyond the last bit of a long slot can never match, so it
  // is refused rather than stored as a trigger that silently never fires.
  function pos_ok;
    input [10:0] v;
    begin
      pos_ok = (v[`FPT_POS_BIT_MSB:0] <= `FPT_MAX_BIT);
    end
  endfunction

  function [CNT_W-1:0] sat_inc;
    input [CNT_W-1:0] v;
    begin
      if (&v) begin
        sat_inc = v;
      end else begin
        sat_inc = v + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // Frame counter compare, shared by the position trigger and the
  // sequencer start so that both act on the same bit boundary.
  function at_pos;
    input [2:0] slot;
    input [7:0] bitp;
    input [2:0] want_slot;
    input [7:0] want_bit;
    begin
      at_pos = (slot == want_slot) && (bitp == want_bit);
    end
  endfunction

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  // The control reset word is split into its bits so that each flop
  // takes exactly one bit of it.
  localparam [2:0] CTRL_RST = `FPT_CTRL_RST;
  // The accumulator sum runs on 17 bits so that the step past the bit
  // period is never lost before the compare.
  localparam [16:0] BIT_STEP = `FPT_BIT_STEP;
  localparam [16:0] BIT_NUM = `FPT_BIT_NUM_NS;

  // ----------------------------------------
  // Registers and wires
  // ----------------------------------------
  reg pos_en_r;
  reg arm_r;
  reg seq_en_r;
  reg [10:0] pos_r;
  reg [DLY_W-1:0] tdly_r;
  reg [2:0] tslot_r;
  reg pos_rej_r;
  reg [CNT_W-1:0] pcnt_r;
  reg [CNT_W-1:0] mcnt_r;
  reg [15:0] acc_r;
  reg bit_en_r;
  reg bit_tick_d_r;
  reg [31:0] rd_nxt;

  wire wr_en;
  wire rd_setup;
  wire acc_err;
  wire [16:0] acc_sum;
  wire [2:0] cur_slot;
  wire [7:0] cur_bit;
  wire pos_match;
  wire pos_rise;
  wire meas_go;
  wire busy_w;
  wire lvl_w;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // The slave answers with no wait state; read data is captured in the
  // setup cycle so that it comes from a flip-flop in the access cycle.
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign acc_err = psel & penable & ~addr_known(paddr);
  // Unmapped addresses answer with an error but still take no wait state.
  assign pslverr = acc_err;

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `FPT_CTRL_OFF: begin
        rd_nxt[`FPT_CTRL_POS_EN] = pos_en_r;
        rd_nxt[`FPT_CTRL_ARM] = arm_r;
        rd_nxt[`FPT_CTRL_SEQ_EN] = seq_en_r;
      end
      `FPT_POS_OFF: begin
        rd_nxt[10:0] = pos_r;
      end
      `FPT_TDLY_OFF: begin
        rd_nxt[DLY_W-1:0] = tdly_r;
      end
      `FPT_TSLOT_OFF: begin
        rd_nxt[2:0] = tslot_r;
      end
      `FPT_STAT_OFF: begin
        rd_nxt[2:0] = cur_slot;
        rd_nxt[`FPT_STAT_BIT_MSB:`FPT_STAT_BIT_LSB] = cur_bit;
        rd_nxt[`FPT_STAT_MEAS_LVL] = lvl_w;
        rd_nxt[`FPT_STAT_BUSY] = busy_w;
        rd_nxt[`FPT_STAT_POS_REJ] = pos_rej_r;
        rd_nxt[`FPT_STAT_POS_TRIG] = pos_trig;
      end
      `FPT_PCNT_OFF: begin
        rd_nxt[CNT_W-1:0] = pcnt_r;
      end
      `FPT_MCNT_OFF: begin
        rd_nxt[CNT_W-1:0] = mcnt_r;
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_nxt;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_en_r <= CTRL_RST[`FPT_CTRL_POS_EN];
      arm_r <= CTRL_RST[`FPT_CTRL_ARM];
      seq_en_r <= CTRL_RST[`FPT_CTRL_SEQ_EN];
      pos_r <= `FPT_POS_RST;
      tdly_r <= `FPT_TDLY_RST;
      tslot_r <= `FPT_TSLOT_RST;
    end else if (wr_en) begin
      case (paddr)
        `FPT_CTRL_OFF: begin
          pos_en_r <= pwdata[`FPT_CTRL_POS_EN];
          arm_r <= pwdata[`FPT_CTRL_ARM];
          seq_en_r <= pwdata[`FPT_CTRL_SEQ_EN];
        end
        `FPT_POS_OFF: begin
          if (pos_ok(pwdata[10:0])) begin
            pos_r <= pwdata[`FPT_POS_SLOT_MSB:0];
          end
        end
        `FPT_TDLY_OFF: begin
          tdly_r <= pwdata[DLY_W-1:0];
        end
        `FPT_TSLOT_OFF: begin
          tslot_r <= pwdata[2:0];
        end
        default: begin
          tslot_r <= tslot_r;
        end
      endcase
    end
  end

  // Refused position writes leave a sticky flag; a refusal in the same
  // cycle as a clear keeps the flag set.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_rej_r <= 1'b0;
    end else if (wr_en && paddr == `FPT_POS_OFF && !pos_ok(pwdata[10:0])) begin
      pos_rej_r <= 1'b1;
    end else if (wr_en && paddr == `FPT_STAT_OFF && pwdata[`FPT_STAT_POS_REJ]) begin
      pos_rej_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Bit clock enable
  // ----------------------------------------
  // A phase accumulator gives the exact 48/13 us bit period on average;
  // single bits jitter by one pclk cycle, which is far below one bit.
  // The remainder is carried over, so no rounding error builds up.
  assign acc_sum = {1'b0, acc_r} + BIT_STEP;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= 16'h0000;
      bit_en_r <= 1'b0;
      bit_tick_d_r <= 1'b0;
    end else begin
      bit_tick_d_r <= bit_en_r;
      if (acc_sum >= BIT_NUM) begin
        acc_r <= acc_sum[15:0] - BIT_NUM[15:0];
        bit_en_r <= 1'b1;
      end else begin
        acc_r <= acc_sum[15:0];
        bit_en_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Frame position counters
  // ----------------------------------------
  // Counting starts at bit zero of slot zero after reset, so the frame
  // reference is the counter wrap, and slot starts give the .75, .50 and
  // .25 bit offsets of slots 1, 2 and 3 (and 5, 6, 7).
  fpt_frame_cnt u_frame (
    .pclk(pclk),
    .presetn(presetn),
    .bit_en(bit_en_r),
    .slot_r(cur_slot),
    .bit_r(cur_bit)
  );

  // ----------------------------------------
  // Frame position trigger
  // ----------------------------------------
  assign pos_match = at_pos(cur_slot, cur_bit, pos_r[`FPT_POS_SLOT_MSB:`FPT_POS_SLOT_LSB],
                            pos_r[`FPT_POS_BIT_MSB:0]);
  assign pos_rise = pos_en_r & pos_match & bit_tick_d_r;

  // The pulse starts in the cycle after the counters reach the match and
  // lasts until they move on, one bit period.
  // A position write while enabled takes effect at once, so a pulse that
  // is already running may be cut short.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_trig <= 1'b0;
    end else begin
      pos_trig <= pos_en_r & pos_match;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt_r <= {CNT_W{1'b0}};
    end else if (pos_rise) begin
      pcnt_r <= sat_inc(pcnt_r);
    end else if (wr_en && paddr == `FPT_PCNT_OFF) begin
      pcnt_r <= {CNT_W{1'b0}};
    end
  end

  // ----------------------------------------
  // Burst start from the sequencer
  // ----------------------------------------
  // The start follows the traffic slot setting, so a measurement can be
  // tied to any one slot of the frame.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_start <= 1'b0;
    end else begin
      burst_start <= seq_en_r & bit_tick_d_r & at_pos(cur_slot, cur_bit, tslot_r, 8'h00);
    end
  end

  // ----------------------------------------
  // Delayed measurement trigger
  // ----------------------------------------
  fpt_meas_dly #(
    .DW(DLY_W)
  ) u_meas (
    .pclk(pclk),
    .presetn(presetn),
    .bit_en(bit_en_r),
    .start(burst_start),
    .arm(arm_r),
    .delay(tdly_r),
    .trig_lvl_r(lvl_w),
    .busy_r(busy_w),
    .go_r(meas_go)
  );

  assign meas_trig_out = lvl_w;
  assign meas_busy = busy_w;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcnt_r <= {CNT_W{1'b0}};
    end else if (meas_go) begin
      mcnt_r <= sat_inc(mcnt_r);
    end else if (wr_en && paddr == `FPT_MCNT_OFF) begin
      mcnt_r <= {CNT_W{1'b0}};
    end
  end

endmodule

//--- tb/fpt_checker.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checker.
// ----------------------------------------
module fpt_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pos_trig,
  input wire logic meas_trig_out,
  input wire logic meas_busy,
  input wire logic burst_start
);
  logic [2:0] ctrl_r;
  logic [6:0] hi_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A shadow of the control word lets the gates be judged from the ports alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 3'h0;
      hi_r <= 7'h00;
    end else begin
      if (psel && penable && pready && pwrite && paddr == 8'h00) begin
        ctrl_r <= pwdata[2:0];
      end
      hi_r <= pos_trig ? hi_r + 7'h01 : 7'h00;
    end
  end
  AST_POS_EN: assert property ($rose(pos_trig) |-> ctrl_r[0])
    else $error("position trigger while disabled");
  AST_POS_MAX: assert property (pos_trig |-> hi_r < 7'd74)
    else $error("position trigger too long");
  AST_POS_MIN: assert property ($fell(pos_trig) && ctrl_r[0] |-> hi_r >= 7'd73)
    else $error("position trigger too short");
  AST_BURST_ONE: assert property (burst_start |=> !burst_start)
    else $error("start pulse too long");
  AST_BURST_SEQ: assert property (burst_start |-> $past(ctrl_r[2]))
    else $error("start pulse while sequencer off");
  AST_BUSY_CAUSE: assert property ($rose(meas_busy) |-> $past(burst_start) && $past(ctrl_r[1]))
    else $error("busy without start");
  AST_TOG_BUSY: assert property ($changed(meas_trig_out) |-> $past(meas_busy) && !meas_busy)
    else $error("toggle outside delay end");
  AST_TOG_ARM: assert property ($changed(meas_trig_out) |-> $past(ctrl_r[1]))
    else $error("toggle while unarmed");
endmodule
bind fpt_top fpt_checker u_chk(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pos_trig(pos_trig),
  .meas_trig_out(meas_trig_out), .meas_busy(meas_busy), .burst_start(burst_start));

//--- tb/fpt_instr_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// External instrument: counts pulses and transitions.
// ----------------------------------------
module fpt_instr_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pos_in,
  input wire logic meas_in,
  output int pos_pulses,
  output int meas_edges
);
  logic pos_d;
  logic meas_d;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_d <= 1'b0;
      meas_d <= 1'b0;
      pos_pulses <= 0;
      meas_edges <= 0;
    end else begin
      pos_d <= pos_in;
      meas_d <= meas_in;
      if (pos_in && !pos_d) pos_pulses <= pos_pulses + 1;
      if (meas_in !== meas_d) meas_edges <= meas_edges + 1;
    end
  end
endmodule

//--- tb/tb_frame_position_trigger.sv
`timescale 1ns/100ps
`define CHK(nm, got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", nm, exp, got); end end
module tb_frame_position_trigger;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [64:0] ex;
  logic [64:0] q[$];
  wire [31:0] prdata;
  wire pready, pslverr, pos_trig, meas_trig_out, meas_busy, burst_start;
  int miscompares, checks_done, pos_pulses, meas_edges, dly, bpos;
  real t0, tb0;
  fpt_top dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pos_trig(pos_trig), .meas_trig_out(meas_trig_out), .meas_busy(meas_busy), .burst_start(burst_start));
  fpt_instr_model inst(.pclk(pclk), .presetn(presetn), .pos_in(pos_trig), .meas_in(meas_trig_out),
    .pos_pulses(pos_pulses), .meas_edges(meas_edges));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Read results are judged against the oldest note left by the driver.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      ex = q.pop_front();
      `CHK("prdata", prdata & ex[63:32], ex[31:0])
      `CHK("pslverr", pslverr, ex[64])
    end
  end
  task conclude;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hffffffff,
           input logic e = 1'b0);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back({e, m, d});
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin miscompares++; conclude(); end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input int k, input logic v, input int lim);
    int n;
    n = 0;
    do begin @(posedge pclk); #1; n++; end while ((k == 0 ? pos_trig : k == 1 ? burst_start : meas_trig_out) !== v
      && n < lim);
    if (n >= lim) begin miscompares++; conclude(); end
  endtask
  // Bit clock is 48000/650 pclk per bit on average; a few cycles of pipeline are allowed.
  function bit near(input real dt, input real bits, input real tol);
    real d;
    d = dt / 50.0 - bits * 48000.0 / 650.0;
    return d <= tol && d >= -tol;
  endfunction
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(25));
    dly = $urandom_range(10, 2);
    bpos = $urandom_range(35, 20) + 5;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t0 = $realtime;
    apb(0, 8'h00, 32'h0);
    apb(1, 8'h04, 32'h09d);
    apb(0, 8'h04, 32'h0);
    apb(0, 8'h10, 32'h40000, 32'h40000);
    apb(0, 8'h1c, 32'h0, 32'hffffffff, 1'b1);
    apb(1, 8'h04, 32'h79c);
    apb(0, 8'h04, 32'h79c);
    apb(1, 8'h04, 32'h100 | bpos);
    apb(1, 8'h08, dly);
    apb(1, 8'h0c, 32'h1);
    apb(1, 8'h00, 32'h7);
    wt(1, 1'b1, 13000);
    tb0 = $realtime - 1;
    `CHK("start_time", near(tb0 - t0, 157.0, 3.0), 1'b1)
    @(posedge pclk);
    #1;
    `CHK("meas_busy", meas_busy, 1'b1)
    wt(2, 1'b1, 2000);
    `CHK("meas_delay", near($realtime - 1 - tb0, dly + 1, 4.0), 1'b1)
    `CHK("meas_busy", meas_busy, 1'b0)
    wt(0, 1'b1, 4000);
    `CHK("pos_time", near($realtime - 1 - t0, 157 + bpos, 4.0), 1'b1)
    apb(0, 8'h10, 32'h80001 | (32'(bpos) << 8), 32'h8ff07);
    wt(0, 1'b0, 200);
    `CHK("pos_pulses", pos_pulses, 1)
    `CHK("meas_edges", meas_edges, 1)
    apb(0, 8'h14, 32'h1);
    apb(0, 8'h18, 32'h1);
    apb(1, 8'h00, 32'h0);
    apb(0, 8'h00, 32'h0);
    conclude();
  end
endmodule
